//--- rtl/pxbar_pkg.sv
package pxbar_pkg;
  // ----------------------------------------------------------------
  // register addresses on the special function register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT0_DRIVE_MODE    = 8'ha4;
  localparam logic [7:0] ADDR_PORT1_DRIVE_MODE    = 8'ha5;
  localparam logic [7:0] ADDR_PORT2_DRIVE_MODE    = 8'ha6;
  localparam logic [7:0] ADDR_PORT3_DRIVE_MODE    = 8'ha7;
  localparam logic [7:0] ADDR_PORT4_DRIVE_MODE    = 8'hae;
  localparam logic [7:0] ADDR_PORT0_ROUTE_BYPASS  = 8'hd4;
  localparam logic [7:0] ADDR_PORT1_ROUTE_BYPASS  = 8'hd5;
  localparam logic [7:0] ADDR_PORT2_ROUTE_BYPASS  = 8'hd6;
  localparam logic [7:0] ADDR_PORT3_ROUTE_BYPASS  = 8'hdf;
  localparam logic [7:0] ADDR_ROUTE_SELECT_FIRST  = 8'he1;
  localparam logic [7:0] ADDR_ROUTE_SELECT_SECOND = 8'he2;
  localparam logic [7:0] ADDR_INPUT_KIND_BASE     = 8'hf1;
  localparam logic [7:0] ADDR_PORT_LATCH_BASE     = 8'hb8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SEL1_UART      = 0;
  localparam int SEL1_SPI       = 1;
  localparam int SEL1_SMBUS     = 2;
  localparam int SEL1_SYSCLK    = 3;
  localparam int SEL1_CMP0      = 4;
  localparam int SEL1_CMP0_ASYN = 5;
  localparam int SEL1_CMP1      = 6;
  localparam int SEL1_CMP1_ASYN = 7;
  localparam int SEL2_ROUTER_EN = 6;
  localparam int SEL2_PULLUP_DIS = 7;

  // ----------------------------------------------------------------
  // peripheral functions in crossbar priority order
  // ----------------------------------------------------------------
  localparam int FN_COUNT  = 13;
  localparam int FN_SDA    = 6;
  localparam int FN_SCL    = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DRIVE_KIND = 8'h00;
  localparam logic [7:0] RST_BYPASS     = 8'h00;
  localparam logic [7:0] RST_INPUT_KIND = 8'hff;
  localparam logic [7:0] RST_LATCH      = 8'hff;
  localparam logic [7:0] RST_SELECT     = 8'h00;
endpackage

//--- rtl/pxbar_port_io.sv
// Behaviour
// - input kind: 1 digital, 0 analog; reset digital
// - analog pin: pull-up, driver, receiver off
// - drive kind: 0 open-drain, 1 push-pull
// - drive kind ignored on analog pins
// - smbus data and clock always open-drain
// - pull-up on open-drain unless pull-up disabled
// - pull-up off while pin drives low
// - router off: pins on ports 0-3 plain input
// - ports 0-3 drivers off; port 4 gpio
// - router enable bit connects peripherals
// - bypass bit skips pin in assignment
// - pins assigned from routing registers only
// - assigned pins keep their drive kind, except smbus data and clock
// - analog path still sees digital pins
module pxbar_port_io #(
  parameter int NUM_PORTS  = 5,
  parameter int XBAR_PORTS = 4
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // special function register bus
  input  wire logic [7:0]               sfr_addr,
  input  wire logic                     sfr_wr,
  input  wire logic                     sfr_rd,
  input  wire logic [7:0]               sfr_wdata,
  output logic      [7:0]               sfr_rdata,
  output logic                          sfr_hit,
  // peripheral side
  input  wire logic [pxbar_pkg::FN_COUNT-1:0] periph_out,
  output logic      [pxbar_pkg::FN_COUNT-1:0] periph_in,
  // pin side
  input  wire logic [NUM_PORTS*8-1:0]   pin_in,
  output logic      [NUM_PORTS*8-1:0]   pin_out,
  output logic      [NUM_PORTS*8-1:0]   pin_oe,
  output logic      [NUM_PORTS*8-1:0]   pin_pullup_en,
  output logic      [NUM_PORTS*8-1:0]   pin_receiver_en
);
  localparam int NP = NUM_PORTS * 8;
  localparam int XP = XBAR_PORTS * 8;
  localparam int FN = pxbar_pkg::FN_COUNT;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] drive_kind [NUM_PORTS];
  logic [7:0] input_kind [NUM_PORTS];
  logic [7:0] port_latch [NUM_PORTS];
  logic [7:0] bypass     [XBAR_PORTS];
  logic [7:0] route_select_first;
  logic [7:0] route_select_second;
  logic [7:0] next_drive_kind [NUM_PORTS];
  logic [7:0] next_input_kind [NUM_PORTS];
  logic [7:0] next_port_latch [NUM_PORTS];
  logic [7:0] next_bypass     [XBAR_PORTS];
  logic [7:0] next_route_select_first;
  logic [7:0] next_route_select_second;
  logic [7:0] next_sfr_rdata;
  logic       next_sfr_hit;

  logic router_enable;
  logic pullup_disable;
  assign router_enable  = route_select_second[pxbar_pkg::SEL2_ROUTER_EN];
  assign pullup_disable = route_select_second[pxbar_pkg::SEL2_PULLUP_DIS];

  // decode writes and reads; unmapped reads return zero with no hit
  always_comb
  begin
    next_route_select_first  = route_select_first;
    next_route_select_second = route_select_second;
    next_sfr_rdata           = 8'h00;
    next_sfr_hit             = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      next_drive_kind[p] = drive_kind[p];
      next_input_kind[p] = input_kind[p];
      next_port_latch[p] = port_latch[p];
      if (sfr_addr == drive_addr(p))
      begin
        next_sfr_hit   = 1'b1;
        next_sfr_rdata = drive_kind[p];
        if (sfr_wr)
          next_drive_kind[p] = sfr_wdata;
      end
      if (sfr_addr == pxbar_pkg::ADDR_INPUT_KIND_BASE + 8'(p))
      begin
        next_sfr_hit   = 1'b1;
        next_sfr_rdata = input_kind[p];
        if (sfr_wr)
          next_input_kind[p] = sfr_wdata;
      end
      if (sfr_addr == pxbar_pkg::ADDR_PORT_LATCH_BASE + 8'(p))
      begin
        // reads see the pin level, as a port read does
        next_sfr_hit   = 1'b1;
        next_sfr_rdata = pin_in[p*8 +: 8];
        if (sfr_wr)
          next_port_latch[p] = sfr_wdata;
      end
    end
    for (int p = 0; p < XBAR_PORTS; p++)
    begin
      next_bypass[p] = bypass[p];
      if (sfr_addr == bypass_addr(p))
      begin
        next_sfr_hit   = 1'b1;
        next_sfr_rdata = bypass[p];
        if (sfr_wr)
          next_bypass[p] = sfr_wdata;
      end
    end
    if (sfr_addr == pxbar_pkg::ADDR_ROUTE_SELECT_FIRST)
    begin
      next_sfr_hit   = 1'b1;
      next_sfr_rdata = route_select_first;
      if (sfr_wr)
        next_route_select_first = sfr_wdata;
    end
    if (sfr_addr == pxbar_pkg::ADDR_ROUTE_SELECT_SECOND)
    begin
      next_sfr_hit   = 1'b1;
      next_sfr_rdata = route_select_second;
      if (sfr_wr)
        next_route_select_second = sfr_wdata;
    end
    if (!sfr_rd)
    begin
      next_sfr_rdata = 8'h00;
      next_sfr_hit   = 1'b0;
    end
  end

  function automatic logic [7:0] drive_addr(input int p);
    unique case (p)
      0:       drive_addr = pxbar_pkg::ADDR_PORT0_DRIVE_MODE;
      1:       drive_addr = pxbar_pkg::ADDR_PORT1_DRIVE_MODE;
      2:       drive_addr = pxbar_pkg::ADDR_PORT2_DRIVE_MODE;
      3:       drive_addr = pxbar_pkg::ADDR_PORT3_DRIVE_MODE;
      default: drive_addr = pxbar_pkg::ADDR_PORT4_DRIVE_MODE;
    endcase
  endfunction

  function automatic logic [7:0] bypass_addr(input int p);
    unique case (p)
      0:       bypass_addr = pxbar_pkg::ADDR_PORT0_ROUTE_BYPASS;
      1:       bypass_addr = pxbar_pkg::ADDR_PORT1_ROUTE_BYPASS;
      2:       bypass_addr = pxbar_pkg::ADDR_PORT2_ROUTE_BYPASS;
      default: bypass_addr = pxbar_pkg::ADDR_PORT3_ROUTE_BYPASS;
    endcase
  endfunction

  // register file
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        drive_kind[p] <= pxbar_pkg::RST_DRIVE_KIND;
        input_kind[p] <= pxbar_pkg::RST_INPUT_KIND;
        port_latch[p] <= pxbar_pkg::RST_LATCH;
      end
      for (int p = 0; p < XBAR_PORTS; p++)
        bypass[p] <= pxbar_pkg::RST_BYPASS;
      route_select_first  <= pxbar_pkg::RST_SELECT;
      route_select_second <= pxbar_pkg::RST_SELECT;
      sfr_rdata           <= 8'h00;
      sfr_hit             <= 1'b0;
    end
    else
    begin
      drive_kind          <= next_drive_kind;
      input_kind          <= next_input_kind;
      port_latch          <= next_port_latch;
      bypass              <= next_bypass;
      route_select_first  <= next_route_select_first;
      route_select_second <= next_route_select_second;
      sfr_rdata           <= next_sfr_rdata;
      sfr_hit             <= next_sfr_hit;
    end
  end

  // ----------------------------------------------------------------
  // priority decoder
  // ----------------------------------------------------------------
  logic [FN-1:0] fn_enable;
  logic [3:0]    fn_list  [FN];
  logic [3:0]    pin_fn   [NP];
  logic [NP-1:0] pin_assigned;

  // expand the routing enables into one bit per function
  always_comb
  begin
    fn_enable[1:0]  = {2{route_select_first[pxbar_pkg::SEL1_UART]}};
    fn_enable[5:2]  = {4{route_select_first[pxbar_pkg::SEL1_SPI]}};
    fn_enable[7:6]  = {2{route_select_first[pxbar_pkg::SEL1_SMBUS]}};
    fn_enable[8]    = route_select_first[pxbar_pkg::SEL1_SYSCLK];
    fn_enable[9]    = route_select_first[pxbar_pkg::SEL1_CMP0];
    fn_enable[10]   = route_select_first[pxbar_pkg::SEL1_CMP0_ASYN];
    fn_enable[11]   = route_select_first[pxbar_pkg::SEL1_CMP1];
    fn_enable[12]   = route_select_first[pxbar_pkg::SEL1_CMP1_ASYN];
  end

  // walk pins upward handing out enabled functions in priority order;
  // a long ripple chain, acceptable since it only changes on sfr writes
  always_comb
  begin
    int cnt;
    int rank;
    cnt  = 0;
    rank = 0;
    for (int f = 0; f < FN; f++)
      fn_list[f] = 4'h0;
    for (int f = 0; f < FN; f++)
    begin
      if (fn_enable[f])
      begin
        fn_list[cnt] = 4'(f);
        cnt = cnt + 1;
      end
    end
    for (int p = 0; p < NP; p++)
    begin
      pin_fn[p]       = 4'h0;
      pin_assigned[p] = 1'b0;
      if (p < XP && router_enable && !bypass[p/8][p%8])
      begin
        if (rank < cnt)
        begin
          pin_fn[p]       = fn_list[rank];
          pin_assigned[p] = 1'b1;
        end
        rank = rank + 1;
      end
    end
  end
  // ----------------------------------------------------------------
  // pin drivers, pull-ups and receivers
  // ----------------------------------------------------------------
  logic [NP-1:0] next_pin_out;
  logic [NP-1:0] next_pin_oe;
  logic [NP-1:0] next_pin_pullup_en;
  logic [NP-1:0] next_pin_receiver_en;
  logic [FN-1:0] next_periph_in;

  for (genvar g = 0; g < NP; g++)
  begin : g_pin
    logic digital;
    logic value;
    logic open_drain;
    logic drive_on;
    logic drive_low;
    assign digital    = input_kind[g/8][g%8];
    // assigned pins still take their drive kind from software, except smbus data and clock, which are forced open-drain
    assign value      = pin_assigned[g] ? periph_out[pin_fn[g]]
                                        : port_latch[g/8][g%8];
    assign open_drain = !drive_kind[g/8][g%8]
                        || (pin_assigned[g] && (pin_fn[g] == 4'(pxbar_pkg::FN_SDA)
                        || pin_fn[g] == 4'(pxbar_pkg::FN_SCL)));
    // ports below the gpio-only port need the router enabled to drive
    assign drive_on   = digital && (g >= XP || router_enable);
    assign drive_low  = drive_on && !value;

    always_comb
    begin
      next_pin_out[g]         = value;
      next_pin_oe[g]          = drive_low || (drive_on && !open_drain);
      next_pin_pullup_en[g]   = digital && open_drain && !pullup_disable
                                && !drive_low;
      // only the digital receiver is gated; the analog tap is never cut
      next_pin_receiver_en[g] = digital;
    end
  end

  // peripheral inputs follow their assigned pin, idle high otherwise
  always_comb
  begin
    next_periph_in = '1;
    for (int p = 0; p < NP; p++)
      if (pin_assigned[p] && input_kind[p/8][p%8])
        next_periph_in[pin_fn[p]] = pin_in[p];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out         <= '1;
      pin_oe          <= '0;
      pin_pullup_en   <= '0;
      pin_receiver_en <= '1;
      periph_in       <= '1;
    end
    else
    begin
      pin_out         <= next_pin_out;
      pin_oe          <= next_pin_oe;
      pin_pullup_en   <= next_pin_pullup_en;
      pin_receiver_en <= next_pin_receiver_en;
      periph_in       <= next_periph_in;
    end
  end
endmodule

//--- testbench/pxbar_port_io_assertions.sv
module pxbar_port_io_chk #(
  parameter int NUM_PORTS  = 5,
  parameter int XBAR_PORTS = 4
) (
  // clock and reset
  input wire logic                             clk,
  input wire logic                             rst,
  // register bus
  input wire logic [7:0]                       sfr_addr,
  input wire logic                             sfr_wr,
  input wire logic                             sfr_rd,
  input wire logic [7:0]                       sfr_wdata,
  input wire logic [7:0]                       sfr_rdata,
  input wire logic                             sfr_hit,
  // peripheral and pin side
  input wire logic [pxbar_pkg::FN_COUNT-1:0]   periph_out,
  input wire logic [pxbar_pkg::FN_COUNT-1:0]   periph_in,
  input wire logic [NUM_PORTS*8-1:0]           pin_in,
  input wire logic [NUM_PORTS*8-1:0]           pin_out,
  input wire logic [NUM_PORTS*8-1:0]           pin_oe,
  input wire logic [NUM_PORTS*8-1:0]           pin_pullup_en,
  input wire logic [NUM_PORTS*8-1:0]           pin_receiver_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // shadow copies of the registers the pin checks depend on
  // ----------------------------------------------------------------
  logic [7:0] sel2_q;
  logic [7:0] ik0_q;

  // follows bus writes only, so a stuck design register shows up
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sel2_q <= pxbar_pkg::RST_SELECT;
      ik0_q  <= pxbar_pkg::RST_INPUT_KIND;
    end
    else
    begin
      if (sfr_wr && sfr_addr == pxbar_pkg::ADDR_ROUTE_SELECT_SECOND)
        sel2_q <= sfr_wdata;
      if (sfr_wr && sfr_addr == pxbar_pkg::ADDR_INPUT_KIND_BASE)
        ik0_q <= sfr_wdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_read_hit;
    sfr_rd && sfr_addr == pxbar_pkg::ADDR_ROUTE_SELECT_FIRST |=> sfr_hit;
  endproperty
  a_read_hit: assert property (p_read_hit) else $error("mapped read without hit");
  property p_unmapped;
    sfr_rd && sfr_addr == 8'h00 |=> !sfr_hit && sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_readback;
    sfr_wr && sfr_addr == pxbar_pkg::ADDR_ROUTE_SELECT_FIRST ##1
      sfr_rd && sfr_addr == pxbar_pkg::ADDR_ROUTE_SELECT_FIRST
      |=> sfr_rdata == $past(sfr_wdata, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("route select lost");
  property p_no_pull_on_driver;
    (pin_pullup_en & pin_oe) == '0;
  endproperty
  a_no_pull_on_driver: assert property (p_no_pull_on_driver)
    else $error("pull-up on driven pin");
  property p_analog_quiet;
    (~pin_receiver_en & (pin_oe | pin_pullup_en)) == '0;
  endproperty
  a_analog_quiet: assert property (p_analog_quiet)
    else $error("analog pin not quiet");
  // pins show the register value one edge late, so compare against the
  // shadow as it stood at the previous edge; a write in between must not count
  property p_router_off;
    !$past(sel2_q[pxbar_pkg::SEL2_ROUTER_EN]) |-> pin_oe[XBAR_PORTS*8-1:0] == '0;
  endproperty
  a_router_off: assert property (p_router_off)
    else $error("driver on with router off");
  property p_pullup_dis;
    $past(sel2_q[pxbar_pkg::SEL2_PULLUP_DIS]) |-> pin_pullup_en == '0;
  endproperty
  a_pullup_dis: assert property (p_pullup_dis)
    else $error("pull-up despite disable");
  property p_receiver;
    pin_receiver_en[7:0] == $past(ik0_q);
  endproperty
  a_receiver: assert property (p_receiver)
    else $error("receiver differs from input kind");

  c_routed_drive: cover property (sel2_q[pxbar_pkg::SEL2_ROUTER_EN] && pin_oe[1]);
  c_read_hit: cover property (sfr_hit);
  c_pullup_on: cover property (|pin_pullup_en);
endmodule

bind pxbar_port_io pxbar_port_io_chk #(
  .NUM_PORTS  (NUM_PORTS),
  .XBAR_PORTS (XBAR_PORTS)
) u_pxbar_port_io_chk (
  .clk (clk), .rst (rst), .sfr_addr (sfr_addr), .sfr_wr (sfr_wr), .sfr_rd (sfr_rd),
  .sfr_wdata (sfr_wdata), .sfr_rdata (sfr_rdata), .sfr_hit (sfr_hit),
  .periph_out (periph_out), .periph_in (periph_in), .pin_in (pin_in), .pin_out (pin_out),
  .pin_oe (pin_oe), .pin_pullup_en (pin_pullup_en), .pin_receiver_en (pin_receiver_en)
);

//--- testbench/pxbar_pins_model.sv
module pxbar_pins_model #(
  parameter int W = 40
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // device side
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] pin_pullup_en,
  // external drivers and resolved level
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip;

  // a floating pin wanders, so no check passes on a lucky settled level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flip <= 1'b0;
    else
      flip <= ~flip;
  end

  // device driver first, then outside source, then weak pull-up
  always_comb
  begin
    for (int i = 0; i < W; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : (pin_pullup_en[i] | flip));
  end
endmodule

//--- testbench/pxbar_port_io_tb.sv
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module pxbar_port_io_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                            clk = 1'b0;
  logic                            rst = 1'b1;
  logic [7:0]                      sfr_addr = 8'h00;
  logic                            sfr_wr = 1'b0;
  logic                            sfr_rd = 1'b0;
  logic [7:0]                      sfr_wdata = 8'h00;
  logic [7:0]                      sfr_rdata;
  logic                            sfr_hit;
  logic [pxbar_pkg::FN_COUNT-1:0]  periph_out = 13'h1fff;
  logic [pxbar_pkg::FN_COUNT-1:0]  periph_in;
  logic [39:0]                     pin_in, pin_out, pin_oe, pin_pullup_en, pin_receiver_en;
  logic [39:0]                     ext_en = 40'h0;
  logic [39:0]                     ext_val = 40'h0;
  int                              err_total = 0;
  int                              compares = 0;

  always #4 clk = ~clk;

  pxbar_port_io u_pxbar_port_io (
    .clk (clk), .rst (rst), .sfr_addr (sfr_addr), .sfr_wr (sfr_wr), .sfr_rd (sfr_rd),
    .sfr_wdata (sfr_wdata), .sfr_rdata (sfr_rdata), .sfr_hit (sfr_hit),
    .periph_out (periph_out), .periph_in (periph_in), .pin_in (pin_in), .pin_out (pin_out),
    .pin_oe (pin_oe), .pin_pullup_en (pin_pullup_en), .pin_receiver_en (pin_receiver_en));
  pxbar_pins_model u_pxbar_pins_model (
    .clk (clk), .rst (rst), .pin_out (pin_out), .pin_oe (pin_oe),
    .pin_pullup_en (pin_pullup_en), .ext_en (ext_en), .ext_val (ext_val), .pin_in (pin_in));

  // ----------------------------------------------------------------
  // bus cycles, entered and left at a falling edge
  // ----------------------------------------------------------------
  // the strobe stays up after a cycle so that back-to-back calls never
  // lower and raise it in one time step; repeating a write is harmless
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_rd = 1'b0;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    sfr_wr = 1'b0;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    @(negedge clk);
    `CHK("read data", e, sfr_rdata)
    `CHK("read hit", h, sfr_hit)
  endtask
  // register to pin takes one edge, pin to peripheral one more
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic t_reset();
    rd(pxbar_pkg::ADDR_ROUTE_SELECT_FIRST, 8'h00, 1'b1);
    rd(pxbar_pkg::ADDR_PORT0_ROUTE_BYPASS, 8'h00, 1'b1);
    rd(pxbar_pkg::ADDR_INPUT_KIND_BASE, 8'hff, 1'b1);
    rd(8'h00, 8'h00, 1'b0);
    `CHK("receivers", {40{1'b1}}, pin_receiver_en)
    `CHK("pullups", {40{1'b1}}, pin_pullup_en)
    `CHK("enables", 40'h0, pin_oe)
  endtask

  task automatic t_router_off();
    wr(pxbar_pkg::ADDR_PORT0_DRIVE_MODE, 8'hff);
    wr(pxbar_pkg::ADDR_PORT_LATCH_BASE, 8'h00);
    wr(pxbar_pkg::ADDR_PORT4_DRIVE_MODE, 8'h0f);
    wr(pxbar_pkg::ADDR_PORT_LATCH_BASE + 8'h04, 8'h5a);
    settle();
    `CHK("p0 oe off", 8'h00, pin_oe[7:0])
    `CHK("p4 oe", 8'haf, pin_oe[39:32])
    `CHK("p4 level", 8'h0a, pin_out[39:32] & pin_oe[39:32])
    `CHK("p4 pullup", 8'h50, pin_pullup_en[39:32])
  endtask

  task automatic t_analog();
    wr(pxbar_pkg::ADDR_INPUT_KIND_BASE, 8'h0f);
    wr(pxbar_pkg::ADDR_ROUTE_SELECT_SECOND, 8'h40);
    settle();
    `CHK("analog oe", 8'h0f, pin_oe[7:0])
    `CHK("analog rcv", 8'h0f, pin_receiver_en[7:0])
    `CHK("analog pull", 8'h00, pin_pullup_en[7:0])
  endtask

  task automatic t_route();
    wr(pxbar_pkg::ADDR_INPUT_KIND_BASE, 8'hff);
    wr(pxbar_pkg::ADDR_PORT0_DRIVE_MODE, 8'hfb);
    wr(pxbar_pkg::ADDR_PORT_LATCH_BASE, 8'hff);
    wr(pxbar_pkg::ADDR_PORT0_ROUTE_BYPASS, 8'h01);
    wr(pxbar_pkg::ADDR_ROUTE_SELECT_FIRST, 8'h01);
    wr(pxbar_pkg::ADDR_ROUTE_SELECT_SECOND, 8'h40);
    periph_out[0] = 1'b0;
    ext_en[2] = 1'b1;
    ext_val[2] = 1'b0;
    settle();
    `CHK("tx low", 3'b100, {pin_oe[1], pin_out[1], pin_pullup_en[1]})
    `CHK("rx low", 1'b0, periph_in[1])
    `CHK("rx pull", 1'b1, pin_pullup_en[2])
    periph_out[0] = 1'b1;
    ext_val[2] = 1'b1;
    settle();
    `CHK("tx high", 2'b11, {pin_oe[1], pin_out[1]})
    `CHK("rx high", 1'b1, periph_in[1])
    ext_en[2] = 1'b0;
  endtask

  task automatic t_smbus();
    wr(pxbar_pkg::ADDR_PORT0_DRIVE_MODE, 8'hff);
    wr(pxbar_pkg::ADDR_PORT0_ROUTE_BYPASS, 8'h00);
    wr(pxbar_pkg::ADDR_ROUTE_SELECT_FIRST, 8'h04);
    rd(pxbar_pkg::ADDR_ROUTE_SELECT_FIRST, 8'h04, 1'b1);
    settle();
    `CHK("sda high", 2'b01, {pin_oe[0], pin_pullup_en[0]})
    `CHK("scl high", 1'b0, pin_oe[1])
    periph_out[pxbar_pkg::FN_SDA] = 1'b0;
    settle();
    `CHK("sda low", 3'b100, {pin_oe[0], pin_out[0], pin_pullup_en[0]})
    periph_out[pxbar_pkg::FN_SDA] = 1'b1;
  endtask

  task automatic t_pullup_off();
    wr(pxbar_pkg::ADDR_PORT0_DRIVE_MODE, 8'h00);
    wr(pxbar_pkg::ADDR_ROUTE_SELECT_SECOND, 8'hc0);
    settle();
    `CHK("no pullups", 40'h0, pin_pullup_en)
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // whole run is under fifty cycles; this only catches a hang
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    settle();
    t_reset();
    t_router_off();
    t_analog();
    t_route();
    t_smbus();
    t_pullup_off();
    print_verdict();
  end
endmodule
